// [rtl/host_port_pkg.sv]
// ==========================================================
// shared constants for the host port
package host_port_pkg;
  // command stack depth and index width
  localparam int CMD_DEPTH = 8;
  localparam int CMD_PTR_W = 3;
  // status register byte count and index width
  localparam int STAT_BYTES = 12;
  localparam int STAT_IDX_W = 4;
  // byte count and buffer address widths
  localparam int COUNT_W = 16;
  localparam int ADDR_W = 16;
  // clock and host byte rate
  localparam int CLK_HZ = 20000000;
  localparam int XFER_RATE_KBPS = 2300;
  // cycles per supplied byte, rounded up
  localparam int BYTE_CYCLES = (CLK_HZ + XFER_RATE_KBPS * 1000 - 1) / (XFER_RATE_KBPS * 1000);
  localparam logic [3:0] BYTE_CYCLES_M1 = 4'(BYTE_CYCLES - 1);
  // least reset pulse, for reference by the outside
  localparam int RESET_MIN_NS = 1000;
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  // transfer states
  typedef enum logic [1:0] {XS_IDLE, XS_FETCH, XS_READY, XS_DONE} xfer_state_t;
endpackage

// [rtl/cmd_stack.sv]
`timescale 1ns/1ps
// ==========================================================
// eight-byte command stack written by the host, drained by the controller
module cmd_stack
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // fill side
  input  wire logic       push,
  input  wire logic [7:0] pushData,
  // drain side
  input  wire logic       pop,
  output logic [7:0]      popData,
  output logic            notEmpty,
  output logic            full
);
  // storage and pointers
  logic [7:0]                          mem_q [host_port_pkg::CMD_DEPTH];
  logic [host_port_pkg::CMD_PTR_W-1:0] wrPtr_q;
  logic [host_port_pkg::CMD_PTR_W-1:0] rdPtr_q;
  logic [host_port_pkg::CMD_PTR_W:0]   count_q;
  // qualified strobes
  wire doPush = push && !full;
  wire doPop  = pop && notEmpty;

  assign full     = (count_q == 4'(host_port_pkg::CMD_DEPTH));
  assign notEmpty = (count_q != 4'h0);
  assign popData  = mem_q[rdPtr_q];

  // ==========================================================
  // storage, one byte per cell
  genvar i;
  generate
    for (i = 0; i < host_port_pkg::CMD_DEPTH; i++)
    begin : g_cell
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          mem_q[i] <= host_port_pkg::BYTE_RST;
        else if (doPush && wrPtr_q == 3'(i))
          mem_q[i] <= pushData;
      end
    end
  endgenerate

  // ==========================================================
  // pointers and fill count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_q <= 3'h0;
      rdPtr_q <= 3'h0;
      count_q <= 4'h0;
    end
    else
    begin
      if (doPush)
        wrPtr_q <= wrPtr_q + 3'h1;
      if (doPop)
        rdPtr_q <= rdPtr_q + 3'h1;
      if (doPush && !doPop)
        count_q <= count_q + 4'h1;
      else if (doPop && !doPush)
        count_q <= count_q - 4'h1;
    end
  end
endmodule

// [rtl/disc_decoder_host_port.sv]
`timescale 1ns/1ps
// How it works
// - eight-byte command stack takes host writes
// - each command write while the stack is not full pulses controller interrupt
// - controller loads count, address, then triggers
// - transfer enable low once trigger seen with a nonzero count
// - wait asserted while a host data read is held before the next byte is ready
// - request mode: output asks for each byte
// - last byte: end marker, enable off, done
// - controller fills twelve status bytes
// - status bytes changed only by controller
// - status ready output tells host
// - strobes ignored unless chip select low, except the read strobe rise that ends a pending data read
// - names ending _n are active low
// - end marker low on final byte
module disc_decoder_host_port
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // host pins
  input  wire logic        host_chip_select_n,
  input  wire logic        host_read_strobe_n,
  input  wire logic        host_write_strobe_n,
  input  wire logic        host_cmd_data_select,
  input  wire logic        request_mode_select,
  input  wire logic [7:0]  hostDataIn,
  output logic [7:0]       hostDataOut,
  output logic             hostDataOe,
  output logic             xfer_enable_n,
  output logic             host_wait_or_request,
  output logic             end_of_process_n,
  output logic             status_ready_n,
  // controller side
  input  wire logic [15:0] byteCountIn,
  input  wire logic [15:0] startAddrIn,
  input  wire logic        xferTrigger,
  input  wire logic        cmdPop,
  output logic [7:0]       cmdByte,
  output logic             cmdNotEmpty,
  output logic             cmdFull,
  output logic             cmdIrq,
  output logic             doneIrq,
  output logic             xferBusy,
  input  wire logic        statWrite,
  input  wire logic [3:0]  statIndex,
  input  wire logic [7:0]  statData,
  input  wire logic        statReadyIn,
  // buffer RAM read port
  output logic [15:0]      ramAddr,
  output logic             ramRead,
  input  wire logic [7:0]  ramData
);
  // ==========================================================
  // pin synchronisers, two flops each
  logic [4:0] pinMeta_q;
  logic [4:0] pinSync_q;
  logic [7:0] dinMeta_q;
  logic [7:0] dinSync_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta_q <= 5'h1F;
      pinSync_q <= 5'h1F;
      dinMeta_q <= host_port_pkg::BYTE_RST;
      dinSync_q <= host_port_pkg::BYTE_RST;
    end
    else
    begin
      pinMeta_q <= {host_chip_select_n, host_read_strobe_n, host_write_strobe_n,
                    host_cmd_data_select, request_mode_select};
      pinSync_q <= pinMeta_q;
      dinMeta_q <= hostDataIn;
      dinSync_q <= dinMeta_q;
    end
  end

  // synchronised pins
  wire csLow   = !pinSync_q[4];
  wire rdLow   = !pinSync_q[3];
  wire wrLow   = !pinSync_q[2];
  wire cmdSel  = pinSync_q[1];
  wire reqMode = pinSync_q[0];

  // previous strobe levels for edge detection
  logic rdLowPrev_q;
  logic wrLowPrev_q;

  wire rdActive = rdLow && csLow;
  wire wrActive = wrLow && csLow;
  wire wrFall   = wrActive && !wrLowPrev_q && cmdSel;
  wire rdFall   = rdActive && !rdLowPrev_q && !cmdSel;
  wire rdRise   = !rdLow && rdLowPrev_q;
  wire statRd   = rdActive && cmdSel;

  // ==========================================================
  // transfer state and datapath registers
  host_port_pkg::xfer_state_t state_q;
  host_port_pkg::xfer_state_t state_d;
  logic [15:0] count_q;
  logic [15:0] addr_q;
  logic [7:0]  dataLatch_q;
  logic [3:0]  pace_q;
  logic        readPending_q;
  logic [3:0]  statPtr_q;
  logic [7:0]  statMem_q [host_port_pkg::STAT_BYTES];
  logic        statRdPrev_q;

  // pacing reaches supply rate
  wire paceDone  = (pace_q == 4'h0);
  wire lastByte  = (count_q == 16'h0001);
  wire byteReady = (state_q == host_port_pkg::XS_READY);
  // one read completed by the host
  wire readDone  = readPending_q && rdRise;

  // ==========================================================
  // next-state decode
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      host_port_pkg::XS_IDLE:
        if (xferTrigger && byteCountIn != 16'h0000)
          state_d = host_port_pkg::XS_FETCH;
      // wait for supply pacing
      host_port_pkg::XS_FETCH:
        if (paceDone)
          state_d = host_port_pkg::XS_READY;
      // byte held for host
      host_port_pkg::XS_READY:
        if (readDone)
          state_d = lastByte ? host_port_pkg::XS_DONE : host_port_pkg::XS_FETCH;
      // report completion
      host_port_pkg::XS_DONE:
        state_d = host_port_pkg::XS_IDLE;
      default:
        state_d = host_port_pkg::XS_IDLE;
    endcase
  end

  // ==========================================================
  // state and strobe history
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q     <= host_port_pkg::XS_IDLE;
      rdLowPrev_q <= 1'b0;
      wrLowPrev_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      rdLowPrev_q <= rdLow;
      wrLowPrev_q <= wrActive;
    end
  end

  // ==========================================================
  // count, address, pacing and byte latch
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_q       <= 16'h0000;
      addr_q        <= 16'h0000;
      pace_q        <= 4'h0;
      dataLatch_q   <= host_port_pkg::BYTE_RST;
      readPending_q <= 1'b0;
    end
    else if (state_q == host_port_pkg::XS_IDLE && state_d == host_port_pkg::XS_FETCH)
    begin
      count_q <= byteCountIn;
      addr_q  <= startAddrIn;
      pace_q  <= host_port_pkg::BYTE_CYCLES_M1;
    end
    else
    begin
      if (state_q == host_port_pkg::XS_FETCH && !paceDone)
        pace_q <= pace_q - 4'h1;
      // latch RAM byte as supply finishes
      if (state_q == host_port_pkg::XS_FETCH && paceDone)
        dataLatch_q <= ramData;
      // a data read held low once the byte is ready, even one begun during wait
      if (byteReady && rdActive && !cmdSel)
        readPending_q <= 1'b1;
      else if (readDone)
        readPending_q <= 1'b0;
      if (byteReady && readDone)
      begin
        count_q <= count_q - 16'h0001;
        addr_q  <= addr_q + 16'h0001;
        pace_q  <= host_port_pkg::BYTE_CYCLES_M1;
      end
    end
  end

  // ==========================================================
  // status bytes and read pointer
  // only controller writes status
  genvar s;
  generate
    for (s = 0; s < host_port_pkg::STAT_BYTES; s++)
    begin : g_stat
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          statMem_q[s] <= host_port_pkg::BYTE_RST;
        else if (statWrite && statIndex == 4'(s))
          statMem_q[s] <= statData;
      end
    end
  endgenerate

  // status read pointer advances per host read
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      statPtr_q    <= 4'h0;
      statRdPrev_q <= 1'b0;
    end
    else
    begin
      statRdPrev_q <= statRd;
      if (!statReadyIn)
        statPtr_q <= 4'h0;
      else if (!statRd && statRdPrev_q)
        statPtr_q <= (statPtr_q == 4'(host_port_pkg::STAT_BYTES - 1)) ? 4'h0 : statPtr_q + 4'h1;
    end
  end

  // ==========================================================
  // command stack
  // eight-byte stack
  cmd_stack u_cmd_stack
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .push     (wrFall),
    .pushData (dinSync_q),
    .pop      (cmdPop),
    .popData  (cmdByte),
    .notEmpty (cmdNotEmpty),
    .full     (cmdFull)
  );

  // ==========================================================
  // output decode
  wire inXfer   = (state_q == host_port_pkg::XS_FETCH) || byteReady;
  wire waitLow  = rdActive && !cmdSel && inXfer && !byteReady;
  wire reqHigh  = byteReady && !readPending_q;
  wire sharedD  = reqMode ? reqHigh : !waitLow;
  wire [7:0] outByte = cmdSel ? statMem_q[statPtr_q] : dataLatch_q;

  // ==========================================================
  // registered outputs
  // low-active pins idle high
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hostDataOut          <= host_port_pkg::BYTE_RST;
      hostDataOe           <= 1'b0;
      xfer_enable_n        <= 1'b1;
      host_wait_or_request <= 1'b1;
      end_of_process_n     <= 1'b1;
      status_ready_n       <= 1'b1;
      cmdIrq               <= 1'b0;
      doneIrq              <= 1'b0;
      xferBusy             <= 1'b0;
      ramAddr              <= 16'h0000;
      ramRead              <= 1'b0;
    end
    else
    begin
      hostDataOut          <= outByte;
      hostDataOe           <= rdActive;
      xfer_enable_n        <= !inXfer;
      host_wait_or_request <= sharedD;
      end_of_process_n     <= !(byteReady && lastByte);
      status_ready_n       <= !statReadyIn;
      cmdIrq               <= wrFall && !cmdFull;
      doneIrq              <= (state_q == host_port_pkg::XS_DONE);
      xferBusy             <= (state_q != host_port_pkg::XS_IDLE);
      ramAddr              <= addr_q;
      ramRead              <= (state_q == host_port_pkg::XS_FETCH);
    end
  end
endmodule

// [test/host_port_monitor.sv]
`timescale 1ns/1ps
// ====================
// host port checker
module host_port_monitor
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // host side
  input wire logic        host_chip_select_n,
  input wire logic        request_mode_select,
  input wire logic        xfer_enable_n,
  input wire logic        host_wait_or_request,
  input wire logic        end_of_process_n,
  input wire logic        status_ready_n,
  // controller side
  input wire logic [15:0] byteCountIn,
  input wire logic        xferTrigger,
  input wire logic        xferBusy,
  input wire logic        statReadyIn,
  input wire logic        cmdIrq,
  input wire logic        doneIrq,
  input wire logic [15:0] ramAddr,
  input wire logic        ramRead
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  cmd_pulse_a: assert property (cmdIrq |=> !cmdIrq)
    else $error("command irq longer than one cycle");
  cs_gate_a: assert property (host_chip_select_n [*8] |=> !cmdIrq)
    else $error("command irq without chip select");
  xfer_start_a: assert property (xferTrigger && !xferBusy && byteCountIn != 16'h0000 |-> ##[1:2] !xfer_enable_n)
    else $error("transfer enable not low after trigger");
  done_pulse_a: assert property (doneIrq |=> xfer_enable_n && !doneIrq)
    else $error("done irq not a pulse after enable off");
  eop_inside_a: assert property (!end_of_process_n |-> !xfer_enable_n)
    else $error("end marker outside transfer");
  stat_copy_a: assert property (1'h1 |=> status_ready_n == !$past(statReadyIn))
    else $error("status ready not copied");
  wait_inside_a: assert property (!request_mode_select [*4] ##0 !host_wait_or_request |-> !xfer_enable_n)
    else $error("wait outside transfer");
  addr_step_a: assert property (!xfer_enable_n && !$past(xfer_enable_n) && ramAddr != $past(ramAddr)
    |-> ramAddr == $past(ramAddr) + 16'h0001)
    else $error("buffer address jumped");
  // buffer fetched only inside a block
  ram_read_a: assert property (ramRead |-> xferBusy && !xfer_enable_n)
    else $error("buffer read outside transfer");
  // main scenarios reached
  eop_seen_c: cover property (!end_of_process_n);
  wait_seen_c: cover property (!request_mode_select && !host_wait_or_request);
  req_seen_c: cover property (request_mode_select && host_wait_or_request && !xfer_enable_n);
endmodule

bind disc_decoder_host_port host_port_monitor host_port_monitor_inst (.*);

// [test/host_reader_model.sv]
`timescale 1ns/1ps
// ====================
// host reader, one byte per strobe
module host_reader_model
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // device outputs and the request mode select pin
  input wire logic       xfer_enable_n,
  input wire logic       host_wait_or_request,
  input wire logic       request_mode_select,
  input wire logic [7:0] hostDataOut,
  // pace select
  input wire logic       slowHost,
  // status read request from the bench
  input wire logic       statRead,
  // strobe and captured byte
  output logic           host_read_strobe_n,
  output logic           rdValid,
  output logic [7:0]     rdData
);
  // read loop, values taken at the edge
  initial
  begin
    host_read_strobe_n = 1'h1;
    rdValid = 1'h0;
    rdData = 8'h00;
    forever
    begin
      @(posedge clk);
      if (rst_b && (statRead || (!xfer_enable_n && (!request_mode_select || host_wait_or_request))))
      begin
        #2;
        host_read_strobe_n = 1'h0;
        repeat (4) @(posedge clk);
        while (!request_mode_select && !host_wait_or_request)
          @(posedge clk);
        rdData = hostDataOut;
        #2;
        rdValid = 1'h1;
        host_read_strobe_n = 1'h1;
        @(posedge clk);
        #2;
        rdValid = 1'h0;
        repeat (slowHost ? 23 : 3) @(posedge clk);
      end
    end
  end
endmodule

// [test/disc_decoder_host_port_tb.sv]
`timescale 1ns/1ps
// ====================
// host port bench
module disc_decoder_host_port_tb;
  // single-bit pins and strobes, and the twelve status byte notes
  logic        clk, rst_b, host_chip_select_n, host_read_strobe_n, host_write_strobe_n;
  logic        host_cmd_data_select, request_mode_select, hostDataOe, xfer_enable_n;
  logic        host_wait_or_request, end_of_process_n, status_ready_n, xferTrigger, cmdPop;
  logic        cmdNotEmpty, cmdFull, cmdIrq, doneIrq, xferBusy, statWrite, statReadyIn;
  logic        ramRead, slowHost, rdValid, statRead;
  logic [7:0]  statVal[12];
  // bytes, counts and addresses
  logic [7:0]  hostDataIn, hostDataOut, cmdByte, statData, ramData, rdData;
  logic [15:0] byteCountIn, startAddrIn, ramAddr;
  logic [3:0]  statIndex;
  // expected notes and counters
  logic [7:0]  rdQ[$], cmdQ[$];
  int          fails = 0, num_checks = 0, irqs = 0;

  disc_decoder_host_port disc_decoder_host_port_inst (.*);
  host_reader_model host_reader_model_inst (.*);

  // buffer contents from address
  function automatic logic [7:0] ramByte(input logic [15:0] a);
    ramByte = a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  assign ramData = ramByte(ramAddr);

  // free running clock
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // wait edges, drive just after
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  // verdict and end of run
  task automatic finish_test();
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // host write toward command stack
  task automatic cmdWrite(input logic csN, input logic [7:0] b);
    host_chip_select_n = csN;
    host_cmd_data_select = 1'h1;
    hostDataIn = b;
    host_write_strobe_n = 1'h0;
    tick(4);
    host_write_strobe_n = 1'h1;
    tick(4);
    host_chip_select_n = 1'h0;
  endtask

  // one block from the controller side
  task automatic xfer(input int n, input logic req, input logic slow);
    int k;
    request_mode_select = req;
    slowHost = slow;
    host_cmd_data_select = 1'h0;
    startAddrIn = 16'($urandom);
    byteCountIn = 16'(n);
    for (k = 0; k < n; k++)
      rdQ.push_back(ramByte(startAddrIn + 16'(k)));
    tick(4);
    xferTrigger = 1'h1;
    tick(1);
    xferTrigger = 1'h0;
    // wait for done before next block
    for (k = 0; k < 900 && doneIrq !== 1'h1; k++)
      tick(1);
    check("doneIrq", 16'h0001, doneIrq);
    tick(1);
    check("xfer_enable_n", 16'h0001, xfer_enable_n);
    check("bytes left", 16'h0000, 16'(rdQ.size()));
  endtask

  // outputs against oldest notes
  always @(posedge clk)
  begin
    if (rdValid === 1'h1)
      check("rdData", rdQ.pop_front(), rdData);
    if (rdValid === 1'h1)
      check("hostDataOe", 16'h0001, hostDataOe);
    if (cmdPop === 1'h1)
      check("cmdByte", cmdQ.pop_front(), cmdByte);
    if (cmdIrq === 1'h1)
      irqs++;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  // main sequence
  initial
  begin
    int         i;
    logic [7:0] b;
    void'($urandom(32'h80D74EF4));
    rst_b = 1'h0;
    statRead = 1'h0;
    host_chip_select_n = 1'h0;
    host_write_strobe_n = 1'h1;
    host_cmd_data_select = 1'h0;
    request_mode_select = 1'h0;
    hostDataIn = 8'h00;
    byteCountIn = 16'h0000;
    startAddrIn = 16'h0000;
    xferTrigger = 1'h0;
    cmdPop = 1'h0;
    statWrite = 1'h0;
    statIndex = 4'h0;
    statData = 8'h00;
    statReadyIn = 1'h0;
    slowHost = 1'h0;
    tick(5);
    check("xfer_enable_n", 16'h0001, xfer_enable_n);
    check("end_of_process_n", 16'h0001, end_of_process_n);
    rst_b = 1'h1;
    tick(3);
    cmdWrite(1'h1, 8'hEE);
    // fill past full, ninth dropped
    for (i = 0; i < 9; i++)
    begin
      b = 8'($urandom);
      if (i < 8)
        cmdQ.push_back(b);
      cmdWrite(1'h0, b);
    end
    check("cmdFull", 16'h0001, cmdFull);
    check("cmd irqs", 16'h0008, 16'(irqs));
    cmdPop = 1'h1;
    tick(8);
    cmdPop = 1'h0;
    tick(1);
    check("cmdNotEmpty", 16'h0000, cmdNotEmpty);
    // controller fills status, flags host
    for (i = 0; i < 12; i++)
    begin
      statIndex = 4'(i);
      statData = 8'($urandom);
      statVal[i] = statData;
      statWrite = 1'h1;
      tick(1);
    end
    statWrite = 1'h0;
    statReadyIn = 1'h1;
    tick(2);
    check("status_ready_n", 16'h0000, status_ready_n);
    // host reads all twelve status bytes and wraps to the first
    for (i = 0; i < 13; i++)
      rdQ.push_back(statVal[i % 12]);
    host_cmd_data_select = 1'h1;
    tick(3);
    statRead = 1'h1;
    for (i = 0; i < 400 && rdQ.size() != 0; i++)
      tick(1);
    statRead = 1'h0;
    tick(6);
    check("status bytes left", 16'h0000, 16'(rdQ.size()));
    statReadyIn = 1'h0;
    xfer(1, 1'h0, 1'h0);
    xfer(6, 1'h0, 1'h0);
    xfer(3, 1'h0, 1'h1);
    xfer(4, 1'h1, 1'h0);
    xfer(2, 1'h1, 1'h1);
    // zero count leaves port idle
    byteCountIn = 16'h0000;
    xferTrigger = 1'h1;
    tick(1);
    xferTrigger = 1'h0;
    tick(3);
    check("xferBusy", 16'h0000, xferBusy);
    finish_test();
  end
endmodule
